// file: pkg/lss_pkg.sv
// Purpose: Constants for the line state monitor and spare byte registers
// Assumes: 6-bit register address, 8-bit register data
// Notes:   Offsets are byte addresses on the link register port
package lss_pkg;

    // Register port widths
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [5:0] OFS_LINE_MON   = 6'h15;
    localparam logic [5:0] OFS_SPARE      = 6'h16;
    localparam logic [5:0] OFS_SPARE_SET  = 6'h17;
    localparam logic [5:0] OFS_SPARE_CLR  = 6'h18;

    // Reset values and unmapped read value
    localparam logic [7:0] RST_LINE_MON   = 8'h00;
    localparam logic [7:0] RST_SPARE      = 8'h00;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;

    // Line level field position and width
    localparam int LINE_CODE_LSB = 0;
    localparam int LINE_CODE_W   = 2;

    // Line level codes
    localparam logic [1:0] CODE_SE0_SQ    = 2'h0;
    localparam logic [1:0] CODE_J_CHIRP   = 2'h1;
    localparam logic [1:0] CODE_K_NOSQ    = 2'h2;
    localparam logic [1:0] CODE_SE1       = 2'h3;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    // Receiver operating mode, driven by the transceiver core
    typedef enum logic [1:0] {
        LSS_MODE_LSFS  = 2'h0,
        LSS_MODE_HS    = 2'h1,
        LSS_MODE_CHIRP = 2'h2
    } lss_mode_t;

endpackage

// file: pkg/lss_line_if.sv
// Purpose: Carries synchronised line receiver levels between block modules
// Assumes: All signals are in the mclk domain after the synchroniser
// Notes:   The synchroniser drives, the register bank reads
`timescale 1ns/1ns
interface lss_line_if;
    logic dp_level;
    logic dm_level;
    logic squelch;
    logic hs_diff_rx_out;

    modport sync_side (output dp_level, output dm_level, output squelch, output hs_diff_rx_out);
    modport reg_side  (input dp_level, input dm_level, input squelch, input hs_diff_rx_out);
endinterface

// file: logic/lss_line_sync.sv
// Purpose: Two-flop synchroniser for the asynchronous line receiver outputs
// Assumes: Receiver outputs are unrelated to mclk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module lss_line_sync #(
    parameter int STAGES = lss_pkg::SYNC_STAGES
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // Raw receiver levels
    input  wire logic         dp_rx,
    input  wire logic         dm_rx,
    input  wire logic         squelch_rx,
    input  wire logic         hs_diff_rx,
    // Synchronised levels
    lss_line_if.sync_side     line
);

    logic [3:0] meta_r;
    logic [3:0] meta_nxt;
    logic [3:0] sync_r;
    logic [3:0] sync_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next values: stage one samples the pins, stage two samples stage one
    always_comb begin
        meta_nxt = {hs_diff_rx, squelch_rx, dm_rx, dp_rx};
        sync_nxt = meta_r;
    end

    // Registers only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hand the settled levels on
    assign line.dp_level       = sync_r[0];
    assign line.dm_level       = sync_r[1];
    assign line.squelch        = sync_r[2];
    assign line.hs_diff_rx_out = sync_r[3];

endmodule

// file: logic/lss_regs.sv
// Purpose: Line state monitor register and spare test byte with set and
//          clear aliases, reached over the link register port
// Assumes: One register access per cycle; read data one cycle after request
// Notes:   Line receiver inputs are asynchronous and pass two flip-flops
//
// Behaviour
// - Read-only line monitor at 0x15
// - Bits 1:0 follow D+ and D- receivers in low and full speed
// - Code 0x0 on SE0 or squelch
// - Code 0x3 on SE1; invalid in high speed
// - Chirp code 0x1: no squelch, receiver high
// - Spare byte at 0x16, reset zero, inert
// - Write 0x17 sets bits written as one
// - 0x17 reads back the spare byte
// - Write 0x18 clears bits written as one
`timescale 1ns/1ns
module lss_regs #(
    parameter int ADDR_W = lss_pkg::ADDR_W,
    parameter int DATA_W = lss_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              resetn,
    // Single-ended and high-speed receiver levels, asynchronous
    input  wire logic              dp_rx,
    input  wire logic              dm_rx,
    input  wire logic              squelch_rx,
    input  wire logic              hs_diff_rx,
    // Receiver operating mode from the transceiver core, same clock
    input  wire lss_pkg::lss_mode_t op_mode,
    // Link register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata_r,
    output logic                   reg_rvalid_r,
    // Live line level code, for observation
    output logic      [1:0]        line_level_code_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    lss_line_if line ();

    logic [1:0]        line_code_nxt;
    logic [DATA_W-1:0] spare_r;
    logic [DATA_W-1:0] spare_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic              rvalid_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Read data for an address; shared by the read path and easy to extend
    function automatic logic [DATA_W-1:0] read_mux(
        input logic [ADDR_W-1:0] addr,
        input logic [1:0]        code,
        input logic [DATA_W-1:0] spare
    );
        logic [DATA_W-1:0] val;
        val = lss_pkg::RD_UNMAPPED;
        case (addr)
            lss_pkg::OFS_LINE_MON: begin
                val = '0;
                val[lss_pkg::LINE_CODE_LSB +: lss_pkg::LINE_CODE_W] = code;
            end
            lss_pkg::OFS_SPARE: begin
                val = spare;
            end
            lss_pkg::OFS_SPARE_SET: begin
                val = spare;
            end
            lss_pkg::OFS_SPARE_CLR: begin
                val = spare;
            end
            default: begin
                val = lss_pkg::RD_UNMAPPED;
            end
        endcase
        return val;
    endfunction

    // Line level code from the settled receiver levels and the mode
    function automatic logic [1:0] line_code(
        input lss_pkg::lss_mode_t mode,
        input logic               dp,
        input logic               dm,
        input logic               sq,
        input logic               hsd
    );
        logic [1:0] c;
        c = lss_pkg::CODE_SE0_SQ;
        case (mode)
            lss_pkg::LSS_MODE_HS: begin
                // Only squelch is meaningful; SE1 cannot be produced here
                if (sq) begin
                    c = lss_pkg::CODE_SE0_SQ;
                end else begin
                    c = lss_pkg::CODE_K_NOSQ;
                end
            end
            lss_pkg::LSS_MODE_CHIRP: begin
                if (sq) begin
                    c = lss_pkg::CODE_SE0_SQ;
                end else if (hsd) begin
                    c = lss_pkg::CODE_J_CHIRP;
                end else begin
                    c = lss_pkg::CODE_K_NOSQ;
                end
            end
            default: begin
                // Low and full speed: bit 0 is D+, bit 1 is D-
                c = {dm, dp};
            end
        endcase
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Receiver synchroniser

    lss_line_sync #(
        .STAGES (lss_pkg::SYNC_STAGES)
    ) u_sync (
        .mclk       (mclk),
        .resetn     (resetn),
        .dp_rx      (dp_rx),
        .dm_rx      (dm_rx),
        .squelch_rx (squelch_rx),
        .hs_diff_rx (hs_diff_rx),
        .line       (line.sync_side)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Line monitor

    // Monitor tracks the line every cycle; no write path reaches it
    always_comb begin
        line_code_nxt = line_code(op_mode, line.dp_level, line.dm_level,
                                  line.squelch, line.hs_diff_rx_out);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            line_level_code_r <= lss_pkg::RST_LINE_MON[1:0];
        end else begin
            line_level_code_r <= line_code_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Spare test byte

    // One storage byte behind three addresses; the aliases only change how
    // a write is applied. Nothing else in the block reads this byte, so it
    // cannot disturb transceiver behaviour.
    always_comb begin
        spare_nxt = spare_r;
        if (reg_wr) begin
            case (reg_addr)
                lss_pkg::OFS_SPARE: begin
                    spare_nxt = reg_wdata;
                end
                lss_pkg::OFS_SPARE_SET: begin
                    spare_nxt = spare_r | reg_wdata;
                end
                lss_pkg::OFS_SPARE_CLR: begin
                    spare_nxt = spare_r & ~reg_wdata;
                end
                default: begin
                    // Monitor and unmapped writes are dropped silently
                    spare_nxt = spare_r;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            spare_r <= lss_pkg::RST_SPARE;
        end else begin
            spare_r <= spare_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Read data is registered so the port sees flop outputs only. A read
    // in the same cycle as a write returns the value before the write.
    always_comb begin
        rvalid_nxt = reg_rd;
        if (reg_rd) begin
            rdata_nxt = read_mux(reg_addr, line_level_code_r, spare_r);
        end else begin
            rdata_nxt = reg_rdata_r;                            // Hold last data
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_r  <= '0;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rdata_r  <= rdata_nxt;
            reg_rvalid_r <= rvalid_nxt;
        end
    end

endmodule

// file: sim/lss_regs_asserts.sv
// Purpose: Port checks for lss_regs
// Assumes: Read data one cycle after the strobe; pins reach the code in 3 edges
// Notes:   Keeps its own copy of the spare byte to judge reads
`timescale 1ns/1ns
module lss_regs_asserts #(
    parameter int ADDR_W = 6,
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               resetn,
    // Line receivers and mode
    input wire logic               dp_rx,
    input wire logic               dm_rx,
    input wire logic               squelch_rx,
    input wire logic               hs_diff_rx,
    input wire lss_pkg::lss_mode_t op_mode,
    // Register port
    input wire logic [ADDR_W-1:0]  reg_addr,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [DATA_W-1:0]  reg_wdata,
    input wire logic [DATA_W-1:0]  reg_rdata_r,
    input wire logic               reg_rvalid_r,
    input wire logic [1:0]         line_level_code_r
);
    logic [7:0] shadow_r;
    logic [1:0] settle_r;
    logic [1:0] mode1_r;
    logic [1:0] mode2_r;
    logic [1:0] mode3_r;
    // Code is judged only once pins and mode have had time to settle
    wire steady = settle_r == 2'h3 && mode1_r == mode2_r && mode2_r == mode3_r;

    ////////////////////////////////////////////////////////////////////////
    // Shadow spare byte, settle counter and mode history
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shadow_r <= 8'h00;
            settle_r <= 2'h0;
            mode1_r  <= 2'h0;
            mode2_r  <= 2'h0;
            mode3_r  <= 2'h0;
        end else begin
            settle_r <= (settle_r == 2'h3) ? settle_r : settle_r + 2'h1;
            mode1_r  <= op_mode;
            mode2_r  <= mode1_r;
            mode3_r  <= mode2_r;
            if (reg_wr) begin
                case (reg_addr)
                    6'h16: shadow_r <= reg_wdata;
                    6'h17: shadow_r <= shadow_r | reg_wdata;
                    6'h18: shadow_r <= shadow_r & ~reg_wdata;
                    default: shadow_r <= shadow_r;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    rd_valid_a: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read strobe gave no valid");
    one_pulse_a: assert property (!reg_rd |=> !reg_rvalid_r)
        else $error("valid without a read");
    mon_read_a: assert property (reg_rd && reg_addr == 6'h15
        |=> reg_rdata_r == {6'h00, $past(line_level_code_r)})
        else $error("monitor read wrong");
    spare_read_a: assert property (reg_rd && reg_addr inside {[6'h16:6'h18]}
        |=> reg_rdata_r == $past(shadow_r)) else $error("spare read wrong");
    unmap_read_a: assert property (reg_rd && !(reg_addr inside {[6'h15:6'h18]})
        |=> reg_rdata_r == 8'h00) else $error("unmapped read not zero");
    // Read data must hold between reads so a slow reader still sees it
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_r))
        else $error("read data moved without a read");
    lsfs_code_a: assert property (steady && mode1_r == 2'h0
        |-> line_level_code_r == {$past(dm_rx, 3), $past(dp_rx, 3)})
        else $error("full speed code wrong");
    hs_code_a: assert property (steady && mode1_r == 2'h1
        |-> line_level_code_r == ($past(squelch_rx, 3) ? 2'h0 : 2'h2))
        else $error("high speed code wrong");
    chirp_code_a: assert property (steady && mode1_r == 2'h2
        |-> line_level_code_r == ($past(squelch_rx, 3) ? 2'h0 :
        $past(hs_diff_rx, 3) ? 2'h1 : 2'h2)) else $error("chirp code wrong");

    set_wr_c: cover property (reg_wr && reg_addr == 6'h17);
    clr_wr_c: cover property (reg_wr && reg_addr == 6'h18);
    chirp_hi_c: cover property (steady && mode1_r == 2'h2 && line_level_code_r == 2'h1);
endmodule

bind lss_regs lss_regs_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_lss_regs_asserts (
    .mclk, .resetn, .dp_rx, .dm_rx, .squelch_rx, .hs_diff_rx, .op_mode, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r, .reg_rvalid_r, .line_level_code_r);

// file: sim/lss_link_model.sv
// Purpose: Link controller model issuing register reads and writes
// Assumes: One access at a time, launched just after a rising edge
// Notes:   Released lines carry inverted values so stale data never matches
`timescale 1ns/1ns
module lss_link_model (
    // Clock
    input  wire logic       mclk,
    // Register port towards the block
    output logic      [5:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata_r,
    input  wire logic       reg_rvalid_r
);
    // Idle port at time zero
    initial begin
        reg_addr = 6'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // Write is taken on the strobe edge; no answer comes back
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // Read answer is registered on the edge that takes the strobe
    task automatic rd(input logic [5:0] a, output logic v, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        // Answer stands for one cycle; take it at the edge that closes it
        @(posedge mclk);
        v = reg_rvalid_r;
        d = reg_rdata_r;
    endtask
endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench for lss_regs
// Assumes: Link model drives the register port; bench drives the line pins
// Notes:   Pins are held long enough for the code to pass the synchroniser
`timescale 1ns/1ns
module tb;
    logic               mclk = 1'b0;
    logic               resetn = 1'b0;
    logic               dp_rx = 1'b0;
    logic               dm_rx = 1'b0;
    logic               squelch_rx = 1'b0;
    logic               hs_diff_rx = 1'b0;
    lss_pkg::lss_mode_t op_mode = lss_pkg::LSS_MODE_LSFS;
    logic [5:0]         reg_addr;
    logic               reg_wr;
    logic               reg_rd;
    logic [7:0]         reg_wdata;
    logic [7:0]         reg_rdata_r;
    logic               reg_rvalid_r;
    logic [1:0]         line_level_code_r;
    int                 err_count = 0;
    int                 cmp_count = 0;
    // Each entry: mode, D+, D-, squelch, diff receiver, expected code
    logic [7:0] tbl [9] = '{8'h00, 8'h21, 8'h12, 8'h33, 8'h48, 8'h62, 8'h8C, 8'h85, 8'hB2};

    always #2 mclk = ~mclk;

    lss_regs u_lss_regs (.mclk, .resetn, .dp_rx, .dm_rx, .squelch_rx, .hs_diff_rx,
        .op_mode, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r, .reg_rvalid_r,
        .line_level_code_r);
    lss_link_model u_lss_link_model (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata_r, .reg_rvalid_r);

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic       v;
        logic [7:0] d;
        u_lss_link_model.rd(a, v, d);
        chk_bit("rvalid", 1'b1, v);
        chk("rdata", e, d);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Spare byte and aliases first, then every line code through the monitor
    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        rd_chk(6'h15, 8'h00);
        rd_chk(6'h16, 8'h00);
        rd_chk(6'h17, 8'h00);
        rd_chk(6'h18, 8'h00);
        u_lss_link_model.wr(6'h16, 8'hA5);
        rd_chk(6'h16, 8'hA5);
        u_lss_link_model.wr(6'h17, 8'h50);
        rd_chk(6'h17, 8'hF5);
        u_lss_link_model.wr(6'h18, 8'h81);
        rd_chk(6'h18, 8'h74);
        u_lss_link_model.wr(6'h15, 8'hFF);
        rd_chk(6'h15, 8'h00);
        rd_chk(6'h16, 8'h74);
        // Mid-run reset must bring a non-zero spare byte back to zero
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rd_chk(6'h16, 8'h00);
        rd_chk(6'h15, 8'h00);
        rd_chk(6'h3F, 8'h00);
        foreach (tbl[i]) begin
            @(posedge mclk);
            op_mode <= lss_pkg::lss_mode_t'(tbl[i][7:6]);
            dp_rx <= tbl[i][5];
            dm_rx <= tbl[i][4];
            squelch_rx <= tbl[i][3];
            hs_diff_rx <= tbl[i][2];
            repeat (4) @(posedge mclk);
            chk("code", {6'h00, tbl[i][1:0]}, {6'h00, line_level_code_r});
            rd_chk(6'h15, {6'h00, tbl[i][1:0]});
        end
        close_out();
    end

    // Watchdog well beyond the 126 cycles the run needs
    initial begin
        #20000;
        err_count++;
        close_out();
    end
endmodule
